// >>> rtl/adchp_pkg.sv
// How it works
// - bit0 one resets device until zero
// - bit1 one clears sync generator
// - bit6 one: write pin means direction
// - bit6 zero: separate read, write pins
// - bit7 picks two's complement or binary
// - bit8 calibrates offset, later results subtract it
// - read strobe starts on last select, write idle
// - read strobe ends on first inactive input
// - active read strobe drives result onto bus
// - write strobe starts on last select, read idle
// - write strobe end loads addressed register
// - read start drops result pending flag quickly
package adchp_pkg;
    // bus and register widths
    localparam int WORD_W = 12;
    localparam int CFG_W  = 10;
    localparam int RES_W  = 10;

    // register address field of the bus word
    localparam int         ADDR_HI  = 11;
    localparam int         ADDR_LO  = 10;
    localparam logic [1:0] CR1_ADDR = 2'h1;

    // field positions of the second control register
    localparam int SOFT_RST_BIT = 0;
    localparam int SYNC_CLR_BIT = 1;
    localparam int DIR_SEL_BIT  = 6;
    localparam int FMT_SEL_BIT  = 7;
    localparam int OFS_CAL_BIT  = 8;

    // reset value, writable bits, fixed reserved ones
    localparam logic [CFG_W-1:0] CFG_RST   = 10'h030;
    localparam logic [CFG_W-1:0] CFG_WMASK = 10'h1c3;
    localparam logic [CFG_W-1:0] CFG_FIXED = 10'h030;

    // result midscale and twos complement sign flip
    localparam logic [RES_W-1:0] RES_MID = 10'h200;

    // idle levels of {select_low_n, select_high, rd_n, wr_n}
    localparam logic [3:0] CTL_IDLE = 4'hb;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int PEND_CLR_NS   = 12;
    localparam int PEND_CLR_CYC  = (PEND_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
                                   (PEND_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // offset calibration states
    typedef enum logic [1:0] {
        ADCHP_CAL_IDLE = 2'h1,
        ADCHP_CAL_ZERO = 2'h2
    } adchp_cal_t;
endpackage

// >>> rtl/adchp_pin_sync.sv
`timescale 1ns/1ps
module adchp_pin_sync #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;
    logic [W-1:0] level_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // three stages; level taken once stages two and three agree
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    ff1_reg[i]   <= RST[i];
                    ff2_reg[i]   <= RST[i];
                    ff3_reg[i]   <= RST[i];
                    level_reg[i] <= RST[i];
                end else begin
                    ff1_reg[i] <= pin_in[i];
                    ff2_reg[i] <= ff1_reg[i];
                    ff3_reg[i] <= ff2_reg[i];
                    if (ff2_reg[i] == ff3_reg[i]) begin
                        level_reg[i] <= ff3_reg[i];
                    end
                end
            end
        end
    endgenerate

    assign level_out = level_reg;
endmodule

// >>> rtl/adchp_host_port.sv
`timescale 1ns/1ps
module adchp_host_port (
    input  wire logic                         clk_in,
    input  wire logic                         resetn_in,
    input  wire logic                         select_low_n_in,
    input  wire logic                         select_high_in,
    input  wire logic                         rd_n_in,
    input  wire logic                         wr_n_in,
    input  wire logic [adchp_pkg::WORD_W-1:0] data_in,
    input  wire logic [adchp_pkg::RES_W-1:0]  result_in,
    input  wire logic                         result_valid_in,
    output logic      [adchp_pkg::WORD_W-1:0] data_out,
    output logic                              data_oe_n_out,
    output logic                              result_pending_flag_out,
    output logic                              device_reset_out,
    output logic                              sync_gen_clear_out,
    output logic                              number_format_sel_out,
    output logic                              force_zero_out
);
    localparam int PEND_DLY = adchp_pkg::PEND_CLR_CYC;

    logic [3:0]                         ctl_sync;
    logic [adchp_pkg::WORD_W-1:0]       data_sync;
    logic                               cs_ok;
    logic                               dir_comb;
    logic                               rd_req;
    logic                               wr_req;
    logic                               rd_int_reg;
    logic                               rd_int_next;
    logic                               wr_int_reg;
    logic                               wr_int_next;
    logic                               rd_rise;
    logic                               wr_commit;
    logic                               cr1_hit;
    logic [adchp_pkg::WORD_W-1:0]       wr_word_reg;
    logic [adchp_pkg::WORD_W-1:0]       wr_word_next;
    logic [adchp_pkg::CFG_W-1:0]        cfg_reg;
    logic [adchp_pkg::CFG_W-1:0]        cfg_next;
    logic [adchp_pkg::CFG_W-1:0]        cfg_written;
    logic                               soft_rst;
    logic                               soft_rst_load;
    logic                               soft_rst_any;
    logic                               cal_start;
    adchp_pkg::adchp_cal_t              cal_reg;
    adchp_pkg::adchp_cal_t              cal_next;
    logic [adchp_pkg::RES_W-1:0]        offset_reg;
    logic [adchp_pkg::RES_W-1:0]        offset_next;
    logic [adchp_pkg::RES_W-1:0]        corr_word;
    logic [adchp_pkg::RES_W-1:0]        fmt_word;
    logic [adchp_pkg::RES_W-1:0]        stage_reg;
    logic [adchp_pkg::RES_W-1:0]        stage_next;
    logic [adchp_pkg::RES_W-1:0]        hold_reg;
    logic [adchp_pkg::RES_W-1:0]        hold_next;
    logic                               user_result;
    logic                               pend_reg;
    logic                               pend_next;
    logic [adchp_pkg::WORD_W-1:0]       dout_reg;
    logic [adchp_pkg::WORD_W-1:0]       dout_next;
    logic                               oe_n_reg;

    // pin synchronisers for strobes and bus
    adchp_pin_sync #(
        .W   (4),
        .RST (adchp_pkg::CTL_IDLE)
    ) u_ctl_sync (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .pin_in    ({select_low_n_in, select_high_in, rd_n_in, wr_n_in}),
        .level_out (ctl_sync)
    );

    adchp_pin_sync #(
        .W   (adchp_pkg::WORD_W),
        .RST ('0)
    ) u_data_sync (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .pin_in    (data_in),
        .level_out (data_sync)
    );

    // pin decode: both selects, then strobe meaning by mode
    assign cs_ok    = !ctl_sync[3] && ctl_sync[2];
    assign dir_comb = cfg_reg[adchp_pkg::DIR_SEL_BIT];
    assign rd_req   = dir_comb ? ctl_sync[0] : !ctl_sync[1];
    assign wr_req   = !ctl_sync[0];

    // internal strobes: start only if the other strobe is idle
    assign rd_int_next = cs_ok && rd_req && (rd_int_reg || !wr_req);
    assign wr_int_next = cs_ok && wr_req && (wr_int_reg || !rd_req);
    assign rd_rise     = rd_int_next && !rd_int_reg;
    assign wr_commit   = wr_int_reg && !wr_int_next;

    // latch bus word while the write strobe is active
    assign wr_word_next = wr_int_next ? data_sync : wr_word_reg;

    // register update on strobe end, address field selects
    assign cr1_hit     = wr_word_reg[adchp_pkg::ADDR_HI:adchp_pkg::ADDR_LO]
                         == adchp_pkg::CR1_ADDR;
    assign cfg_written = (wr_word_reg[adchp_pkg::CFG_W-1:0] & adchp_pkg::CFG_WMASK)
                         | adchp_pkg::CFG_FIXED;
    assign cfg_next    = !(wr_commit && cr1_hit) ? cfg_reg :
                         cfg_written[adchp_pkg::SOFT_RST_BIT] ?
                         (adchp_pkg::CFG_RST | 10'h001) : cfg_written;
    assign soft_rst    = cfg_reg[adchp_pkg::SOFT_RST_BIT];

    // soft reset also acts in the cycle of the write that sets it
    assign soft_rst_load = wr_commit && cr1_hit
                           && cfg_written[adchp_pkg::SOFT_RST_BIT];
    assign soft_rst_any  = soft_rst || soft_rst_load;

    // offset calibration sequence
    assign cal_start   = wr_commit && cr1_hit && !cfg_written[adchp_pkg::SOFT_RST_BIT]
                         && cfg_written[adchp_pkg::OFS_CAL_BIT];
    assign cal_next    = soft_rst_any ? adchp_pkg::ADCHP_CAL_IDLE :
                         cal_start ? adchp_pkg::ADCHP_CAL_ZERO :
                         (cal_reg == adchp_pkg::ADCHP_CAL_ZERO && result_valid_in) ?
                         adchp_pkg::ADCHP_CAL_IDLE : cal_reg;
    assign offset_next = soft_rst_any ? '0 :
                         (cal_reg == adchp_pkg::ADCHP_CAL_ZERO && result_valid_in) ?
                         result_in - adchp_pkg::RES_MID : offset_reg;

    // result path: subtract offset, then pick number format
    assign corr_word   = result_in - offset_reg;
    assign fmt_word    = cfg_reg[adchp_pkg::FMT_SEL_BIT] ? corr_word
                         : corr_word ^ adchp_pkg::RES_MID;
    assign user_result = result_valid_in && !soft_rst
                         && cal_reg == adchp_pkg::ADCHP_CAL_IDLE;
    assign stage_next  = user_result ? fmt_word : stage_reg;
    assign hold_next   = rd_int_reg ? hold_reg : stage_reg;

    // pending flag: a new result wins over a read start
    assign pend_next   = soft_rst_any ? 1'b0 :
                         user_result ? 1'b1 :
                         rd_rise ? 1'b0 : pend_reg;

    // bus drive while the read strobe is active
    assign dout_next   = rd_int_next ? {2'h0, hold_next} : '0;

    // strobe state
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_int_reg  <= 1'b0;
            wr_int_reg  <= 1'b0;
            wr_word_reg <= '0;
        end else begin
            rd_int_reg  <= rd_int_next;
            wr_int_reg  <= wr_int_next;
            wr_word_reg <= wr_word_next;
        end
    end

    // control register and calibration
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_reg    <= adchp_pkg::CFG_RST;
            cal_reg    <= adchp_pkg::ADCHP_CAL_IDLE;
            offset_reg <= '0;
        end else begin
            cfg_reg    <= cfg_next;
            cal_reg    <= cal_next;
            offset_reg <= offset_next;
        end
    end

    // result words, flag and bus outputs
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stage_reg <= '0;
            hold_reg  <= '0;
            pend_reg  <= 1'b0;
            dout_reg  <= '0;
            oe_n_reg  <= 1'b1;
        end else begin
            stage_reg <= stage_next;
            hold_reg  <= hold_next;
            pend_reg  <= pend_next;
            dout_reg  <= dout_next;
            oe_n_reg  <= !rd_int_next;
        end
    end

    // outputs straight from flops
    assign data_out                = dout_reg;
    assign data_oe_n_out           = oe_n_reg;
    assign result_pending_flag_out = pend_reg;
    assign device_reset_out        = cfg_reg[adchp_pkg::SOFT_RST_BIT];
    assign sync_gen_clear_out      = cfg_reg[adchp_pkg::SYNC_CLR_BIT];
    assign number_format_sel_out   = cfg_reg[adchp_pkg::FMT_SEL_BIT];
    assign force_zero_out          = cal_reg[1];

    // checks
    rd_start_ok_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(rd_int_reg) |-> $past(cs_ok && rd_req && !wr_req))
        else $error("read strobe started without selects or with write active");

    rd_stop_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !(cs_ok && rd_req) |=> !rd_int_reg)
        else $error("read strobe did not end with its inputs");

    rd_drive_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(rd_int_reg) |-> !data_oe_n_out
        && data_out[adchp_pkg::RES_W-1:0] == $past(stage_reg))
        else $error("read strobe did not drive held result");

    wr_start_ok_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(wr_int_reg) |-> $past(cs_ok && wr_req && !rd_req))
        else $error("write strobe started without selects or with read active");

    wr_load_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_commit && cr1_hit && !wr_word_reg[0] |=>
        cfg_reg[8:6] == $past(wr_word_reg[8:6]) && cfg_reg[5:4] == 2'h3)
        else $error("write strobe end did not load register");

    soft_rst_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        soft_rst |-> cfg_reg[9:1] == adchp_pkg::CFG_RST[9:1]
        && cal_reg == adchp_pkg::ADCHP_CAL_IDLE && !result_pending_flag_out)
        else $error("soft reset did not hold reset values");

    sync_clr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_commit && cr1_hit && wr_word_reg[1] && !wr_word_reg[0] |=> sync_gen_clear_out)
        else $error("sync generator clear not set by write");

    dir_mode_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        dir_comb && cs_ok |=> rd_int_reg == $past(ctl_sync[0]))
        else $error("combined direction pin decoded wrongly");

    sep_mode_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !dir_comb && cs_ok && ctl_sync[0] |=> rd_int_reg == !$past(ctl_sync[1]))
        else $error("separate read pin decoded wrongly");

    fmt_sel_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        user_result |=> stage_reg[9] == ($past(corr_word[9]) ^ !$past(cfg_reg[7])))
        else $error("result format sign bit wrong");

    ofs_cap_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        cal_reg == adchp_pkg::ADCHP_CAL_ZERO && result_valid_in && !soft_rst_any |=>
        offset_reg == $past(result_in) - adchp_pkg::RES_MID
        && !force_zero_out
        && !result_pending_flag_out == !($past(pend_reg) && !$past(rd_rise)))
        else $error("offset not captured from zero conversion");

    pend_clr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        rd_rise && !user_result |-> ##PEND_DLY !result_pending_flag_out)
        else $error("pending flag not dropped at read start");

    addr_ignore_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        wr_commit && !cr1_hit |=> cfg_reg == $past(cfg_reg))
        else $error("foreign address changed the register");

    bus_idle_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        data_oe_n_out |-> data_out == 12'h000)
        else $error("data driven while output buffers off");

    read_seen_c:  cover property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(rd_int_reg) && result_pending_flag_out);
    write_seen_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        wr_commit && cr1_hit);
    cal_seen_c:   cover property (@(posedge clk_in) disable iff (!resetn_in)
        $fell(force_zero_out));
    comb_rd_c:    cover property (@(posedge clk_in) disable iff (!resetn_in)
        dir_comb && $rose(rd_int_reg));
endmodule

// >>> test/adchp_host_model.sv
`timescale 1ns/1ps
// bus master model of the host processor
module adchp_host_model (
    input  wire logic                         clk_in,
    input  wire logic [adchp_pkg::WORD_W-1:0] data_in,
    input  wire logic                         data_oe_n_in,
    output logic                              select_low_n_out,
    output logic                              select_high_out,
    output logic                              rd_n_out,
    output logic                              wr_n_out,
    output logic      [adchp_pkg::WORD_W-1:0] data_out
);
    // selects and strobes back to inactive levels
    task automatic idle();
        select_low_n_out = 1'h1;
        select_high_out  = 1'h0;
        rd_n_out         = 1'h1;
        wr_n_out         = 1'h1;
    endtask

    initial begin
        idle();
        data_out = 12'h000;
    end

    // write cycle, word held past the strobe for the pin path
    task automatic write_word(input logic [11:0] w);
        @(posedge clk_in);
        #5;
        data_out         = w;
        wr_n_out         = 1'h0;
        select_low_n_out = 1'h0;
        select_high_out  = 1'h1;
        repeat (6) @(posedge clk_in);
        #5;
        idle();
        repeat (4) @(posedge clk_in);
        #5;
        data_out = ~w; // released bus, no keeper
    endtask

    // read cycle, held until output enable is seen
    task automatic read_word(input logic comb, output logic [11:0] w);
        w = 'x;
        @(posedge clk_in);
        #5;
        data_out         = ~data_out;
        rd_n_out         = comb;
        select_low_n_out = 1'h0;
        select_high_out  = 1'h1;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_in);
            #1;
            if (data_oe_n_in === 1'h0) begin
                w = data_in;
                break;
            end
        end
        #4;
        idle();
    endtask

    // read with one select held inactive, no cycle may start
    task automatic half_select(input logic lo_n, input logic hi, output logic seen);
        seen = 1'h0;
        @(posedge clk_in);
        #5;
        rd_n_out         = 1'h0;
        select_low_n_out = lo_n;
        select_high_out  = hi;
        repeat (8) begin
            @(posedge clk_in);
            #1;
            seen = seen | ~data_oe_n_in;
        end
        #4;
        idle();
    endtask

    // both strobes at once, neither cycle may start
    task automatic clash(output logic seen);
        seen = 1'h0;
        @(posedge clk_in);
        #5;
        data_out         = 12'h400;
        rd_n_out         = 1'h0;
        wr_n_out         = 1'h0;
        select_low_n_out = 1'h0;
        select_high_out  = 1'h1;
        repeat (8) begin
            @(posedge clk_in);
            #1;
            seen = seen | ~data_oe_n_in;
        end
        #4;
        idle();
    endtask
endmodule

// >>> test/adchp_host_port_tb.sv
`timescale 1ns/1ps
module adchp_host_port_tb;
    logic        clk_in, resetn_in, res_vld, sel_n, sel_h, rd_n, wr_n;
    logic        oe_n, pend, dev_rst, sync_clr, fmt, fz, seen;
    logic [9:0]  res;
    logic [11:0] bus_w, bus_r, word;
    int          err_total, num_checks;

    adchp_host_port uut (
        .clk_in                  (clk_in),
        .resetn_in               (resetn_in),
        .select_low_n_in         (sel_n),
        .select_high_in          (sel_h),
        .rd_n_in                 (rd_n),
        .wr_n_in                 (wr_n),
        .data_in                 (bus_w),
        .result_in               (res),
        .result_valid_in         (res_vld),
        .data_out                (bus_r),
        .data_oe_n_out           (oe_n),
        .result_pending_flag_out (pend),
        .device_reset_out        (dev_rst),
        .sync_gen_clear_out      (sync_clr),
        .number_format_sel_out   (fmt),
        .force_zero_out          (fz)
    );

    adchp_host_model host (
        .clk_in           (clk_in),
        .data_in          (bus_r),
        .data_oe_n_in     (oe_n),
        .select_low_n_out (sel_n),
        .select_high_out  (sel_h),
        .rd_n_out         (rd_n),
        .wr_n_out         (wr_n),
        .data_out         (bus_w)
    );

    // 100 ns clock
    initial begin
        clk_in = 1'h0;
        forever #50 clk_in = ~clk_in;
    end

    // compare tasks
    task automatic chk_word(input string n, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %b seen %b", n, e, g);
            err_total++;
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #5;
    endtask

    // one-cycle conversion result from the core
    task automatic pulse_result(input logic [9:0] v);
        @(posedge clk_in);
        #5;
        res     = v;
        res_vld = 1'h1;
        wait_cyc(1);
        res_vld = 1'h0;
        res     = ~v;
        wait_cyc(2);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        end_sim();
    end

    // test sequence
    initial begin
        err_total  = 0;
        num_checks = 0;
        resetn_in  = 1'h0;
        res        = 10'h000;
        res_vld    = 1'h0;
        wait_cyc(2);
        resetn_in = 1'h1;
        wait_cyc(1);
        chk_bit("oe_n reset", 1'h1, oe_n);
        chk_bit("format reset", 1'h0, fmt);
        chk_bit("soft reset", 1'h0, dev_rst);
        chk_word("data reset", 12'h000, bus_r);
        // separate strobes, twos complement
        pulse_result(10'h123);
        chk_bit("pending set", 1'h1, pend);
        // one select inactive starts nothing
        host.half_select(1'h0, 1'h0, seen);
        chk_bit("select high idle", 1'h0, seen);
        host.half_select(1'h1, 1'h1, seen);
        chk_bit("select low idle", 1'h0, seen);
        chk_bit("pending kept", 1'h1, pend);
        host.read_word(1'h0, word);
        chk_word("read twos", 12'h323, word);
        chk_bit("pending clear", 1'h0, pend);
        wait_cyc(6);
        chk_bit("oe_n end", 1'h1, oe_n);
        chk_word("data end", 12'h000, bus_r);
        // binary format and sync clear, then a foreign address
        host.write_word(12'h482);
        wait_cyc(2);
        chk_bit("format", 1'h1, fmt);
        chk_bit("sync clear", 1'h1, sync_clr);
        host.write_word(12'h800);
        wait_cyc(2);
        chk_bit("format kept", 1'h1, fmt);
        // both strobes at once start nothing
        host.clash(seen);
        wait_cyc(6);
        chk_bit("clash read", 1'h0, seen);
        chk_bit("clash write", 1'h1, fmt);
        pulse_result(10'h123);
        host.read_word(1'h0, word);
        chk_word("read binary", 12'h123, word);
        // combined direction pin
        host.write_word(12'h4c0);
        wait_cyc(2);
        pulse_result(10'h0f0);
        host.read_word(1'h1, word);
        chk_word("read combined", 12'h0f0, word);
        // offset calibration, twos complement
        host.write_word(12'h540);
        wait_cyc(2);
        chk_bit("force zero", 1'h1, fz);
        pulse_result(10'h205);
        chk_bit("cal done", 1'h0, fz);
        chk_bit("cal pending", 1'h0, pend);
        pulse_result(10'h210);
        host.read_word(1'h1, word);
        chk_word("read offset", 12'h00b, word);
        // soft reset holds until cleared
        host.write_word(12'h441);
        wait_cyc(2);
        chk_bit("in reset", 1'h1, dev_rst);
        chk_bit("format back", 1'h0, fmt);
        pulse_result(10'h111);
        chk_bit("ignored result", 1'h0, pend);
        host.write_word(12'h400);
        wait_cyc(2);
        chk_bit("out of reset", 1'h0, dev_rst);
        pulse_result(10'h111);
        host.read_word(1'h0, word);
        chk_word("read after reset", 12'h311, word);
        // hardware reset in mid-run
        host.write_word(12'h482);
        wait_cyc(2);
        pulse_result(10'h0aa);
        resetn_in = 1'h0;
        wait_cyc(2);
        resetn_in = 1'h1;
        wait_cyc(1);
        chk_bit("sync clear hw reset", 1'h0, sync_clr);
        chk_bit("format hw reset", 1'h0, fmt);
        chk_bit("pending hw reset", 1'h0, pend);
        chk_bit("oe_n hw reset", 1'h1, oe_n);
        end_sim();
    end
endmodule
